// file: shared/smc_consts.svh
// register map, field positions, reset values and warm-up counts
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
// ====================================================================
// register offsets (byte addresses)
`define SMC_OFF_CTL1 12'h038
`define SMC_OFF_CTL2 12'h03C
`define SMC_OFF_TMR 12'h040
`define SMC_OFF_STAT 12'h044
// ====================================================================
// reset values
`define SMC_RST_CTL1 8'h00
`define SMC_RST_CTL2 8'h80
`define SMC_RST_TMR 8'h00
// ====================================================================
// system_control_one fields
`define SMC_B_HALT 7
`define SMC_B_WAKE_RELEASE_METHOD 6
`define SMC_B_WAKE_RETURN_SELECT 5
`define SMC_B_KEEP 4
`define SMC_B_WUT_HI 3
`define SMC_B_WUT_LO 2
// system_control_two fields
`define SMC_B_FOSC 7
`define SMC_B_SOSC 6
`define SMC_B_SEL 5
`define SMC_B_WAIT 4
`define SMC_B_GATE 2
`define SMC_CTL2_MASK 8'hF4
// timer_wake_control fields
`define SMC_B_BTEN 0
`define SMC_B_BTIE 1
`define SMC_B_IME 2
`define SMC_B_LATCH 3
`define SMC_B_SRC_LO 4
`define SMC_B_SRC_HI 5
// ====================================================================
// warm-up lengths in oscillator periods, fast then slow, codes 00..11
`define SMC_WU_W 18
`define SMC_WU_F0 196608
`define SMC_WU_F1 65536
`define SMC_WU_F2 49152
`define SMC_WU_F3 16384
`define SMC_WU_S0 24576
`define SMC_WU_S1 8192
`define SMC_WU_S2 192
`define SMC_WU_S3 64
`endif

// file: shared/smc_pkg.sv
// types shared by the standby mode controller files
`include "smc_consts.svh"
package smc_pkg;
	// ================================================================
	// operating modes, gray coded along the usual path
	typedef enum logic [3:0] {
		SMC_RUN_SINGLE = 4'h0,
		SMC_WAIT_SINGLE = 4'h1,
		SMC_RUN_DUAL = 4'h3,
		SMC_WAIT_DUAL = 4'h2,
		SMC_RUN_BOTH = 4'h6,
		SMC_WAIT_BOTH = 4'h7,
		SMC_RUN_FOFF = 4'h5,
		SMC_WAIT_FOFF = 4'h4,
		SMC_WAIT_GATED_LOW = 4'hC,
		SMC_WAIT_GATED_FAST = 4'hD,
		SMC_HALT = 4'hF,
		SMC_WARMUP = 4'hE
	} smc_mode_e;
	// ================================================================
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} smc_sync_s;
	typedef struct packed {
		logic [`SMC_WU_W-1:0] cnt;
		logic busy;
		logic done;
	} smc_wu_s;
	typedef struct packed {
		smc_mode_e mode;
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		logic [7:0] tmr;
		logic [31:0] rdata;
		logic bt_armed;
		logic src_prev;
		logic pin_prev;
		logic self_rst;
		logic resume;
		logic wu_load;
	} smc_top_s;
endpackage : smc_pkg

// file: core/smc_sync3.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
module smc_sync3
	import smc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic sync_out
);
	smc_sync_s q, d;
	// ================================================================
	// stage one feeds only stage two; the level moves on agreement
	always_comb begin
		d = q;
		d.s1 = async_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3) begin
			d.level = q.s3;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign sync_out = q.level;
endmodule : smc_sync3

// file: core/smc_warmup.sv
// warm-up down counter, loaded on wake and advanced on oscillator ticks
`timescale 1ns/100ps
module smc_warmup
	import smc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [`SMC_WU_W-1:0] count,
	input wire logic tick,
	output logic done
);
	smc_wu_s q, d;
	// ================================================================
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (load) begin
			d.cnt = count;
			d.busy = 1'b1;
		end else if (q.busy && tick) begin
			if (q.cnt <= `SMC_WU_W'(1)) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt - `SMC_WU_W'(1);
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign done = q.done;
endmodule : smc_warmup

// file: core/smc_standby_ctrl.sv
// standby mode controller: mode sequencer, clock gating, apb registers
`timescale 1ns/100ps
module smc_standby_ctrl
	import smc_pkg::*;
#(
	parameter int WU_F0 = `SMC_WU_F0,
	parameter int WU_F1 = `SMC_WU_F1,
	parameter int WU_F2 = `SMC_WU_F2,
	parameter int WU_F3 = `SMC_WU_F3,
	parameter int WU_S0 = `SMC_WU_S0,
	parameter int WU_S1 = `SMC_WU_S1,
	parameter int WU_S2 = `SMC_WU_S2,
	parameter int WU_S3 = `SMC_WU_S3
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic halt_wake_pin,
	input wire logic wake_irq_req,
	input wire logic [3:0] base_timer_src,
	input wire logic slow_tick,
	output logic [3:0] mode,
	output logic fast_osc_run,
	output logic slow_osc_run,
	output logic main_clock_select,
	output logic cpu_clk_en,
	output logic wdt_clk_en,
	output logic periph_clk_en,
	output logic base_timer_clk_en,
	output logic div_stage1_clk_en,
	output logic port_hold_hiz,
	output logic port_input_zero,
	output logic halt_wake_pin_port_hiz,
	output logic base_timer_irq_latch,
	output logic base_timer_irq_take,
	output logic resume_pulse,
	output logic resume_via_irq,
	output logic self_reset_req
);
	smc_top_s q, d;
	logic pin_s;
	logic wu_done;
	logic wu_tick;
	logic src_now;
	logic src_fall;
	logic pin_rise;
	logic wake;
	logic mapped;
	logic wr;
	logic is_halt;
	logic is_run;
	logic is_gated;
	logic [`SMC_WU_W-1:0] wu_count;
	// ================================================================
	// helpers
	function automatic smc_mode_e run_of(input logic [7:0] c);
		if (c[`SMC_B_SEL]) begin
			run_of = c[`SMC_B_FOSC] ? SMC_RUN_BOTH : SMC_RUN_FOFF;
		end else begin
			run_of = c[`SMC_B_SOSC] ? SMC_RUN_DUAL : SMC_RUN_SINGLE;
		end
	endfunction : run_of

	function automatic smc_mode_e wait_of(input smc_mode_e m);
		case (m)
		SMC_RUN_DUAL: wait_of = SMC_WAIT_DUAL;
		SMC_RUN_BOTH: wait_of = SMC_WAIT_BOTH;
		SMC_RUN_FOFF: wait_of = SMC_WAIT_FOFF;
		default: wait_of = SMC_WAIT_SINGLE;
		endcase
	endfunction : wait_of

	// both off, or the oscillator feeding the main clock switched off
	function automatic logic bad_osc(input logic [7:0] c);
		bad_osc = (!c[`SMC_B_FOSC] && !c[`SMC_B_SOSC]) ||
			(!c[`SMC_B_FOSC] && !c[`SMC_B_SEL]) ||
			(!c[`SMC_B_SOSC] && c[`SMC_B_SEL]);
	endfunction : bad_osc

	function automatic logic is_reg(input logic [11:0] a);
		is_reg = (a == `SMC_OFF_CTL1) || (a == `SMC_OFF_CTL2) ||
			(a == `SMC_OFF_TMR) || (a == `SMC_OFF_STAT);
	endfunction : is_reg

	// ================================================================
	// submodules
	smc_sync3 u_wake_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(halt_wake_pin),
		.sync_out(pin_s)
	);

	smc_warmup u_warmup (
		.pclk(pclk),
		.presetn(presetn),
		.load(q.wu_load),
		.count(wu_count),
		.tick(wu_tick),
		.done(wu_done)
	);

	// ================================================================
	// warm-up length and tick source
	always_comb begin
		wu_count = '0;
		case ({q.ctl1[`SMC_B_WAKE_RETURN_SELECT], q.ctl1[`SMC_B_WUT_HI:`SMC_B_WUT_LO]})
		3'h0: wu_count = `SMC_WU_W'(WU_F0);
		3'h1: wu_count = `SMC_WU_W'(WU_F1);
		3'h2: wu_count = `SMC_WU_W'(WU_F2);
		3'h3: wu_count = `SMC_WU_W'(WU_F3);
		3'h4: wu_count = `SMC_WU_W'(WU_S0);
		3'h5: wu_count = `SMC_WU_W'(WU_S1);
		3'h6: wu_count = `SMC_WU_W'(WU_S2);
		default: wu_count = `SMC_WU_W'(WU_S3);
		endcase
	end
	// fast return counts pclk, which runs from the fast oscillator
	assign wu_tick = q.ctl1[`SMC_B_WAKE_RETURN_SELECT] ? slow_tick : 1'b1;

	// ================================================================
	// event detection
	assign src_now =
		base_timer_src[q.tmr[`SMC_B_SRC_HI:`SMC_B_SRC_LO]];
	assign src_fall = q.src_prev && !src_now;
	assign pin_rise = pin_s && !q.pin_prev;
	// level mode: a pin already high lets warm-up start at once
	assign wake = q.ctl1[`SMC_B_WAKE_RELEASE_METHOD] ? pin_s : pin_rise;
	assign mapped = is_reg(paddr);
	assign wr = psel && penable && pwrite && mapped;

	// ================================================================
	// next state
	always_comb begin
		d = q;
		d.self_rst = 1'b0;
		d.resume = 1'b0;
		d.wu_load = 1'b0;
		d.src_prev = src_now;
		d.pin_prev = pin_s;
		// read data captured in the setup cycle
		if (psel && !penable && !pwrite) begin
			case (paddr)
			`SMC_OFF_CTL1: d.rdata = {24'h000000, q.ctl1[7:2], 2'b00};
			`SMC_OFF_CTL2: d.rdata = {24'h000000, q.ctl2};
			`SMC_OFF_TMR: d.rdata = {24'h000000, q.tmr};
			`SMC_OFF_STAT: d.rdata = {27'h0000000, q.bt_armed, q.mode};
			default: d.rdata = 32'h00000000;
			endcase
		end
		// mode sequencing works on the registered values, so a write
		// takes effect the cycle after its access phase
		case (q.mode)
		SMC_RUN_SINGLE, SMC_RUN_DUAL, SMC_RUN_BOTH, SMC_RUN_FOFF: begin
			if (q.ctl1[`SMC_B_HALT]) begin
				d.mode = SMC_HALT;
			end else if (q.ctl2[`SMC_B_GATE]) begin
				d.bt_armed = q.tmr[`SMC_B_BTEN];
				if (q.ctl2[`SMC_B_SEL]) begin
					d.mode = SMC_WAIT_GATED_LOW;
				end else begin
					d.mode = SMC_WAIT_GATED_FAST;
				end
			end else if (q.ctl2[`SMC_B_WAIT]) begin
				d.mode = wait_of(q.mode);
			end else begin
				d.mode = run_of(q.ctl2);
			end
		end
		SMC_WAIT_SINGLE, SMC_WAIT_DUAL, SMC_WAIT_BOTH, SMC_WAIT_FOFF: begin
			if (wake_irq_req) begin
				d.ctl2[`SMC_B_WAIT] = 1'b0;
				d.mode = run_of(q.ctl2);
				d.resume = 1'b1;
			end
		end
		SMC_WAIT_GATED_LOW, SMC_WAIT_GATED_FAST: begin
			if (src_fall) begin
				d.ctl2[`SMC_B_GATE] = 1'b0;
				d.resume = 1'b1;
				if (q.mode == SMC_WAIT_GATED_LOW) begin
					d.ctl2[`SMC_B_FOSC] = 1'b0;
					d.mode = SMC_RUN_FOFF;
				end else begin
					d.mode = SMC_RUN_SINGLE;
				end
				if (q.bt_armed) begin
					d.tmr[`SMC_B_LATCH] = 1'b1;
				end
				d.bt_armed = 1'b0;
			end
		end
		SMC_HALT: begin
			if (wake) begin
				d.mode = SMC_WARMUP;
				d.wu_load = 1'b1;
			end
		end
		SMC_WARMUP: begin
			if (wu_done) begin
				d.ctl1[`SMC_B_HALT] = 1'b0;
				d.resume = 1'b1;
				if (q.ctl1[`SMC_B_WAKE_RETURN_SELECT]) begin
					d.ctl2[`SMC_B_SEL] = 1'b1;
					d.ctl2[`SMC_B_FOSC] = 1'b0;
					d.mode = SMC_RUN_FOFF;
				end else begin
					d.ctl2[`SMC_B_SEL] = 1'b0;
					d.ctl2[`SMC_B_FOSC] = 1'b1;
					d.mode = q.ctl2[`SMC_B_SOSC] ?
						SMC_RUN_DUAL : SMC_RUN_SINGLE;
				end
			end
		end
		default: d.mode = SMC_RUN_SINGLE;
		endcase
		// register writes
		if (wr) begin
			case (paddr)
			`SMC_OFF_CTL1: d.ctl1 = {pwdata[7:2], 2'b00};
			`SMC_OFF_CTL2: begin
				if (bad_osc(pwdata[7:0])) begin
					d.self_rst = 1'b1;
				end else begin
					d.ctl2 = pwdata[7:0] & `SMC_CTL2_MASK;
				end
			end
			`SMC_OFF_TMR: begin
				d.tmr = {2'b00, pwdata[5:4],
					q.tmr[`SMC_B_LATCH] & ~pwdata[3], pwdata[2:0]};
			end
			default: d.rdata = q.rdata;
			endcase
		end
		// a latch set by the gated exit beats a clear in the same cycle
		if (q.mode == SMC_WAIT_GATED_LOW || q.mode == SMC_WAIT_GATED_FAST)
		begin
			if (src_fall && q.bt_armed) begin
				d.tmr[`SMC_B_LATCH] = 1'b1;
			end
		end
		// an illegal oscillator write behaves like a device reset
		if (d.self_rst) begin
			d.mode = SMC_RUN_SINGLE;
			d.ctl1 = `SMC_RST_CTL1;
			d.ctl2 = `SMC_RST_CTL2;
			d.tmr = `SMC_RST_TMR;
			d.bt_armed = 1'b0;
		end
	end

	// ================================================================
	// state register; reset lands in fast single run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.mode <= SMC_RUN_SINGLE;
			q.ctl1 <= `SMC_RST_CTL1;
			q.ctl2 <= `SMC_RST_CTL2;
			q.tmr <= `SMC_RST_TMR;
			q.rdata <= 32'h00000000;
			q.bt_armed <= 1'b0;
			q.src_prev <= 1'b0;
			q.pin_prev <= 1'b0;
			q.self_rst <= 1'b0;
			q.resume <= 1'b0;
			q.wu_load <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ================================================================
	// apb answer: zero wait states, error on unmapped addresses
	assign prdata = q.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ================================================================
	// clock gating and pin control
	assign is_halt = (q.mode == SMC_HALT) || (q.mode == SMC_WARMUP);
	assign is_run = (q.mode == SMC_RUN_SINGLE) ||
		(q.mode == SMC_RUN_DUAL) || (q.mode == SMC_RUN_BOTH) ||
		(q.mode == SMC_RUN_FOFF);
	assign is_gated = (q.mode == SMC_WAIT_GATED_LOW) ||
		(q.mode == SMC_WAIT_GATED_FAST);
	assign mode = q.mode;
	// oscillators enabled in ctl2 restart at wake so that warm-up can count them
	assign fast_osc_run = q.ctl2[`SMC_B_FOSC] &&
		(q.mode != SMC_HALT);
	assign slow_osc_run = q.ctl2[`SMC_B_SOSC] &&
		(q.mode != SMC_HALT);
	assign main_clock_select = q.ctl2[`SMC_B_SEL];
	assign cpu_clk_en = is_run;
	assign wdt_clk_en = is_run;
	// gated wait stops peripherals until the source edge releases it
	assign periph_clk_en = !is_halt && !is_gated;
	assign base_timer_clk_en = !is_halt;
	assign div_stage1_clk_en = !is_halt &&
		(q.mode != SMC_RUN_FOFF) && (q.mode != SMC_WAIT_FOFF);
	assign port_hold_hiz = is_halt && !q.ctl1[`SMC_B_KEEP];
	// forcing inputs low may raise a falling-edge interrupt downstream
	assign port_input_zero = is_halt && !q.ctl1[`SMC_B_KEEP];
	assign halt_wake_pin_port_hiz = is_halt;
	assign base_timer_irq_latch = q.tmr[`SMC_B_LATCH];
	assign base_timer_irq_take = q.tmr[`SMC_B_IME] &&
		q.tmr[`SMC_B_BTIE] && q.tmr[`SMC_B_BTEN] &&
		q.tmr[`SMC_B_LATCH];
	assign resume_pulse = q.resume;
	assign resume_via_irq = q.resume && q.tmr[`SMC_B_IME];
	assign self_reset_req = q.self_rst;
endmodule : smc_standby_ctrl

// file: bench/smc_wake_src.sv
// wake pin source model: raises the halt wake pin for a set time
`timescale 1ns/100ps
module smc_wake_src (
	input wire logic pclk,
	input wire logic go,
	input wire logic [7:0] hold,
	output logic halt_wake_pin
);
	logic [7:0] cnt_q = 8'h00;
	// =============================================================
	// pin logic
	// a long hold gives a level, a short one a single rising edge
	always @(posedge pclk) begin
		if (go) begin
			cnt_q <= hold;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
	assign halt_wake_pin = (cnt_q != 8'h00);
endmodule : smc_wake_src

// file: bench/smc_standby_checker.sv
// concurrent checks on the standby mode controller ports
`timescale 1ns/100ps
module smc_standby_checker
	import smc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic wake_irq_req,
	input wire logic [3:0] mode,
	input wire logic fast_osc_run,
	input wire logic slow_osc_run,
	input wire logic cpu_clk_en,
	input wire logic wdt_clk_en,
	input wire logic periph_clk_en,
	input wire logic base_timer_clk_en,
	input wire logic div_stage1_clk_en,
	input wire logic halt_wake_pin_port_hiz,
	input wire logic base_timer_irq_latch,
	input wire logic base_timer_irq_take,
	input wire logic resume_pulse,
	input wire logic self_reset_req
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// =============================================================
	// sequences
	sequence wr_halt;
		psel && penable && pwrite && paddr == 12'h038 && pwdata[7]
			&& !pwdata[6] && mode == 4'h0;
	endsequence
	sequence wu_end;
		mode == 4'hE ##1 mode != 4'hE;
	endsequence
	sequence gate_end;
		mode == 4'hC ##1 mode != 4'hC;
	endsequence
	// =============================================================
	// assertions
	chk_halt_start:
	assert property (wr_halt |-> ##2 mode == 4'hF)
		else $error("halt not entered");
	chk_halt_stops:
	assert property (mode == 4'hF |-> !fast_osc_run && !slow_osc_run
		&& !cpu_clk_en && !periph_clk_en) else $error("halt runs");
	chk_pin_float:
	assert property (mode == 4'hF || mode == 4'hE |->
		halt_wake_pin_port_hiz) else $error("wake pin driven");
	chk_div_stop:
	assert property (mode == 4'h5 || mode == 4'h4 |-> !div_stage1_clk_en)
		else $error("divider clocked");
	chk_dual_wait:
	assert property (mode == 4'h2 |-> fast_osc_run && slow_osc_run
		&& !cpu_clk_en && periph_clk_en) else $error("dual wait bad");
	chk_both_wait:
	assert property (mode == 4'h7 |-> fast_osc_run && slow_osc_run
		&& !cpu_clk_en && !wdt_clk_en) else $error("both wait bad");
	chk_low_wait:
	assert property (mode == 4'h4 |-> !fast_osc_run && slow_osc_run
		&& !cpu_clk_en && !wdt_clk_en) else $error("low wait bad");
	chk_wait_release:
	assert property (mode == 4'h4 && wake_irq_req |=> mode == 4'h5)
		else $error("wait not released");
	chk_gated_clocks:
	assert property (mode == 4'hC |-> !cpu_clk_en && !periph_clk_en
		&& base_timer_clk_en) else $error("gated clocks bad");
	chk_gated_exit:
	assert property (gate_end |-> mode == 4'h5)
		else $error("gated exit mode bad");
	chk_warm_resume:
	assert property (wu_end |-> ##[0:1] resume_pulse)
		else $error("no resume pulse");
	chk_take_latch:
	assert property ($rose(base_timer_irq_take) |-> base_timer_irq_latch
		&& ($rose(base_timer_irq_latch) || ($past(psel) && $past(penable)
		&& $past(pwrite) && $past(paddr) == 12'h040
		&& $past(pwdata[2:0]) == 3'h7)))
		else $error("take without all enables");
	chk_osc_reset:
	assert property (psel && penable && pwrite && paddr == 12'h03C
		&& pwdata[7:6] == 2'b00 |=> self_reset_req)
		else $error("no self reset");
endmodule : smc_standby_checker
bind smc_standby_ctrl smc_standby_checker u_chk (.*);

// file: bench/standby_mode_controller_bench.sv
// self-checking bench for the standby mode controller
`timescale 1ns/100ps
`include "smc_consts.svh"
module standby_mode_controller_bench
	import smc_pkg::*;
;
	localparam int WU[4] = '{16, 12, 8, 4};
	localparam int LIMIT = 20000;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic wake_irq_req = 0, slow_tick = 0, go = 0, k;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [3:0] mode, base_timer_src = 0;
	logic [7:0] hold = 0, d;
	logic pready, pslverr, fast_osc_run, slow_osc_run, main_clock_select;
	logic cpu_clk_en, wdt_clk_en, periph_clk_en, base_timer_clk_en;
	logic div_stage1_clk_en, port_hold_hiz, port_input_zero, e;
	logic halt_wake_pin_port_hiz, base_timer_irq_latch, base_timer_irq_take;
	logic resume_pulse, resume_via_irq, self_reset_req, halt_wake_pin;
	int seed = 74885, rnd, fails = 0, samples_checked = 0, cyc = 0, n;
	smc_standby_ctrl #(.WU_F0(WU[0]), .WU_F1(WU[1]), .WU_F2(WU[2]),
		.WU_F3(WU[3]), .WU_S0(WU[0]), .WU_S1(WU[1]), .WU_S2(WU[2]),
		.WU_S3(WU[3])) u_dut (.*);
	smc_wake_src u_wake (.pclk(pclk), .go(go), .hold(hold),
		.halt_wake_pin(halt_wake_pin));
	initial begin
		forever #25 pclk = ~pclk;
	end
	// =============================================================
	// free-running stimulus and timeout
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		rnd = $random(seed);
		slow_tick <= (cyc[1:0] == 2'h3);
		base_timer_src <= {rnd[2:0], cyc[4]};
		if (cyc == LIMIT) begin
			fails++;
			end_of_test();
		end
	end
	// =============================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] dt, output logic [31:0] rd_o, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, dt};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_o = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] dt);
		apb(1'b1, a, dt, r, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00, r, e);
		chk(r, {24'h0, x});
	endtask : rd
	task automatic wait_mode(input logic [3:0] m);
		int i;
		i = 0;
		do begin
			@(posedge pclk);
			#1;
			i++;
		end while (mode !== m && i < 400);
		chk(mode, m);
	endtask : wait_mode
	task automatic pulse(input logic wake, input logic [7:0] h);
		@(posedge pclk);
		wake_irq_req <= wake;
		go <= !wake;
		hold <= h;
		@(posedge pclk);
		wake_irq_req <= 1'b0;
		go <= 1'b0;
	endtask : pulse
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	// =============================================================
	// scenarios
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(`SMC_OFF_CTL1, `SMC_RST_CTL1);
		rd(`SMC_OFF_CTL2, `SMC_RST_CTL2);
		rd(`SMC_OFF_TMR, `SMC_RST_TMR);
		apb(1'b0, 12'h100, 8'h00, r, e);
		chk(e, 1'b1);
		chk(r, 32'h0);
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed)) & 8'h7F;
			wr(`SMC_OFF_CTL1, d);
			rd(`SMC_OFF_CTL1, d & 8'h7C);
		end
		wr(`SMC_OFF_CTL1, 8'h00);
		$display("test registers done");
		wr(`SMC_OFF_CTL2, 8'h90);
		wait_mode(4'h1);
		pulse(1'b1, 8'h00);
		wait_mode(4'h0);
		wr(`SMC_OFF_CTL2, 8'h84);
		wait_mode(4'hD);
		wait_mode(4'h0);
		rd(`SMC_OFF_CTL2, 8'h80);
		wr(`SMC_OFF_CTL2, 8'hC0);
		wait_mode(4'h3);
		wr(`SMC_OFF_CTL2, 8'hD0);
		wait_mode(4'h2);
		pulse(1'b1, 8'h00);
		wait_mode(4'h3);
		rd(`SMC_OFF_CTL2, 8'hC0);
		wr(`SMC_OFF_CTL2, 8'h60);
		wait_mode(4'h5);
		chk(div_stage1_clk_en, 1'b0);
		wr(`SMC_OFF_CTL2, 8'h70);
		wait_mode(4'h4);
		pulse(1'b1, 8'h00);
		wait_mode(4'h5);
		chk(main_clock_select, 1'b1);
		wr(`SMC_OFF_CTL2, 8'hE0);
		wait_mode(4'h6);
		wr(`SMC_OFF_TMR, 8'h04);
		wr(`SMC_OFF_CTL2, 8'hF0);
		wait_mode(4'h7);
		chk(fast_osc_run & slow_osc_run, 1'b1);
		pulse(1'b1, 8'h00);
		#1;
		chk(resume_via_irq, 1'b1);
		wait_mode(4'h6);
		$display("test wait done");
		wr(`SMC_OFF_TMR, 8'h01);
		wr(`SMC_OFF_CTL2, 8'h64);
		wait_mode(4'hC);
		wait_mode(4'h5);
		rd(`SMC_OFF_CTL2, 8'h60);
		rd(`SMC_OFF_TMR, 8'h09);
		wr(`SMC_OFF_TMR, 8'h07);
		#1;
		chk(base_timer_irq_take, 1'b1);
		wr(`SMC_OFF_TMR, 8'h06);
		#1;
		chk(base_timer_irq_take, 1'b0);
		wr(`SMC_OFF_TMR, 8'h08);
		$display("test gated done");
		wr(`SMC_OFF_CTL1, 8'hEC);
		@(posedge pclk);
		#1;
		chk(mode, 4'hF);
		pulse(1'b0, 8'd40);
		wait_mode(4'h5);
		rd(`SMC_OFF_CTL2, 8'h60);
		rd(`SMC_OFF_CTL1, 8'h6C);
		wr(`SMC_OFF_CTL2, 8'h00);
		repeat (3) @(posedge pclk);
		rd(`SMC_OFF_CTL2, `SMC_RST_CTL2);
		$display("test slow halt done");
		for (int c = 0; c < 4; c++) begin
			// an edge release needs the pin seen low before the pulse
			wait (halt_wake_pin === 1'b0);
			repeat (4) @(posedge pclk);
			k = c[0];
			d = 8'h80 | 8'(k << 4) | 8'(c << 2);
			wr(`SMC_OFF_CTL1, d);
			wait_mode(4'hF);
			chk(port_hold_hiz, !k);
			chk(port_input_zero, !k);
			chk(halt_wake_pin_port_hiz, 1'b1);
			chk(cpu_clk_en | fast_osc_run, 1'b0);
			pulse(1'b0, 8'd6);
			wait_mode(4'hE);
			n = 0;
			while (mode === 4'hE && n < 60) begin
				@(posedge pclk);
				#1;
				n++;
			end
			chk(n >= WU[c] && n <= WU[c] + 2, 1'b1);
			chk(mode, 4'h0);
			rd(`SMC_OFF_CTL1, d & 8'h7F);
		end
		pulse(1'b0, 8'd60);
		repeat (8) @(posedge pclk);
		wr(`SMC_OFF_CTL1, 8'h80);
		repeat (10) @(posedge pclk);
		#1;
		chk(mode, 4'hF);
		wait (halt_wake_pin === 1'b0);
		repeat (4) @(posedge pclk);
		pulse(1'b0, 8'd6);
		wait_mode(4'h0);
		pulse(1'b0, 8'd60);
		repeat (8) @(posedge pclk);
		wr(`SMC_OFF_CTL1, 8'hC0);
		repeat (30) @(posedge pclk);
		rd(`SMC_OFF_CTL1, 8'h40);
		$display("test fast halt done");
		wr(`SMC_OFF_CTL2, 8'h60);
		wait_mode(4'h5);
		wr(`SMC_OFF_CTL1, 8'hA0);
		wait_mode(4'hF);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		chk(mode, 4'h0);
		rd(`SMC_OFF_CTL1, 8'h00);
		rd(`SMC_OFF_CTL2, `SMC_RST_CTL2);
		$display("test reset halt done");
		end_of_test();
	end
endmodule : standby_mode_controller_bench
